// *** include/delay_timer_pkg.sv ***
// Purpose : shared constants, types and register layout of the selectable delay timer
// Assumes : 25 MHz module clock, 16-bit register port
// Notes   : time-outs are counted in a 0.1 ms time base

package delay_timer_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 16;
   localparam int PRESET_W = 16;
   localparam int CTRL_W   = 3;
   localparam int TICK_W   = 12;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
   localparam logic [ADDR_W-1:0] FIRST_OFS  = 8'h04;
   localparam logic [ADDR_W-1:0] SECOND_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 40;
   localparam int TICK_PERIOD_NS = 100000;   // 0.1 ms
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic {
      MODE_ON_DELAY,
      MODE_ON_OFF
   } timer_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ON_WAIT,
      ST_HIGH,
      ST_OFF_WAIT
   } timer_state_t;

   typedef struct packed {
      logic        chain_stage_pick;
      logic        delay_choice;
      timer_mode_t mode;
   } ctrl_t;

   typedef struct packed {
      logic [11:0] zero;
      logic        busy;
      logic        trigger;
      logic        tracking;
      logic        timed;
   } status_t;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam ctrl_t                 CTRL_RST   = 3'h4;
   localparam logic [PRESET_W-1:0]   PRESET_RST = 16'h0000;
   localparam logic [DATA_W-1:0]     RDATA_RST  = 16'h0000;

endpackage

// *** logic/tick_divider.sv ***
// Purpose : one-cycle 0.1 ms tick enable from the module clock
// Assumes : i_restart realigns the tick phase to a time-out launch
// Notes   : first tick comes TICK_CYCLES cycles after a restart

`timescale 1ns/100ps

module tick_divider
   import delay_timer_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_restart,
   output logic      o_tick
);

   localparam logic [TICK_W-1:0] TICK_TOP = TICK_W'(TICK_CYCLES - 1);

   logic [TICK_W-1:0] cnt_reg;
   logic [TICK_W-1:0] cnt_next;

   assign o_tick   = (cnt_reg == TICK_TOP);
   assign cnt_next = (i_restart || o_tick) ? '0 : cnt_reg + TICK_W'(1);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_tick_spacing: assert property (o_tick |=> !o_tick [*8]) // [R21]
      else $error("tick repeated too soon");
   a_restart_phase: assert property (i_restart |=> cnt_reg == '0) // [R18]
      else $error("restart did not realign tick phase");

endmodule

// *** logic/trigger_sampler.sv ***
// Purpose : brings the trigger pin into the clock domain and finds its edges
// Assumes : trigger is asynchronous to i_clk
// Notes   : edges are seen two cycles after the pin moves

`timescale 1ns/100ps

module trigger_sampler
   import delay_timer_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges from the synchronised level only
   assign o_level = sync_reg;                 // [R21]
   assign o_rise  = sync_reg & ~prev_reg;     // [R21]
   assign o_fall  = ~sync_reg & prev_reg;     // [R21]

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_edge_rise_level: assert property (o_rise |-> o_level && !o_fall) // [R21]
      else $error("rise seen without high level");
   a_edge_fall_level: assert property (o_fall |-> !o_level ##1 !o_fall) // [R21]
      else $error("fall seen without low level");

endmodule

// *** logic/selectable_delay_timer.sv ***
// Purpose : two-value on-delay and on/off-delay timer for one discrete output channel
// Assumes : trigger is a pin or a previous block's timed output; 25 MHz clock
// Notes   : registers over a plain address/strobe port, read data one cycle later
//
// How it works
// [R1] on-delay mode: trigger rise launches the time-out picked by delay_choice
// [R2] on-delay mode: expiry sets both outputs; early trigger fall keeps timed low
// [R3] blocks chain, each timed output feeding the next trigger
// [R4] in a chain only the stage with chain_stage_pick 0 runs its time-out
// [R5] far side never selects two chained stages at once
// [R6] chained on-delay: timed output drops on trigger fall
// [R7] on-delay mode: timed and tracking outputs always equal
// [R8] far side changes choice and pick only while first trigger is low
// [R9] chain_stage_pick 1: timed output follows the trigger
// [R10] chain_stage_pick 0: block applies its own time-out
// [R11] on/off mode: choice 0 first on, second off; choice 1 swapped
// [R12] on/off mode: trigger rise launches on-delay and raises tracking
// [R13] on/off mode: on expiry timed rises, tracking falls; short pulse ignored
// [R14] on/off mode: trigger fall launches off-delay and raises tracking
// [R15] on/off mode: off-delay uses the preset not used as on-delay
// [R16] chained on/off: only the selected stage sets timed, clears tracking
// [R17] tracking output is brought out for monitoring
// [R18] presets count in 0.1 ms ticks
// [R19] on-delay mode: choice 0 first preset, choice 1 second preset
// [R20] on/off mode: off expiry with trigger low clears timed; rise keeps it
// [R21] counters step on a one-cycle tick; edges from the synchronised trigger

`timescale 1ns/100ps

module selectable_delay_timer
   import delay_timer_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_trigger,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [DATA_W-1:0]      o_rdata,
   output logic                   o_timed_output,
   output logic                   o_tracking_output
);

   // ************************************************************
   // signals
   // ************************************************************
   ctrl_t               ctrl_reg;
   logic [PRESET_W-1:0] first_reg;
   logic [PRESET_W-1:0] second_reg;
   logic [DATA_W-1:0]   rdata_reg;
   logic [DATA_W-1:0]   rd_mux;
   timer_state_t        state_reg;
   timer_state_t        state_next;
   logic [PRESET_W-1:0] count_reg;
   logic [PRESET_W-1:0] count_next;
   logic                timed_reg;
   logic                timed_next;
   logic                track_reg;
   logic                track_next;
   logic                load_on;
   logic                load_off;
   logic                restart;
   logic                tick;
   logic                trig_level;
   logic                trig_rise;
   logic                trig_fall;
   logic                selected;
   logic                on_delay_mode;
   logic                expired;
   logic [PRESET_W-1:0] on_preset;
   logic [PRESET_W-1:0] off_preset;
   status_t             status_word;

   // ************************************************************
   // trigger sampling and time base
   // ************************************************************
   trigger_sampler u_sampler (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_trigger),
      .o_level   (trig_level),
      .o_rise    (trig_rise),
      .o_fall    (trig_fall)
   );

   tick_divider u_divider (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_restart (restart),
      .o_tick    (tick)
   );

   // ************************************************************
   // decoding
   // ************************************************************
   assign selected      = ~ctrl_reg.chain_stage_pick;                 // [R10] [R4]
   assign on_delay_mode = (ctrl_reg.mode == MODE_ON_DELAY);
   assign on_preset     = ctrl_reg.delay_choice ? second_reg : first_reg; // [R19] [R11]
   assign off_preset    = ctrl_reg.delay_choice ? first_reg : second_reg; // [R15] [R11]
   assign expired       = (count_reg == '0);
   assign restart       = load_on | load_off;                          // [R18]

   // ************************************************************
   // timer sequencing
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      timed_next = timed_reg;
      track_next = track_reg;
      load_on    = 1'b0;
      load_off   = 1'b0;
      if (tick && !expired) begin
         count_next = count_reg - PRESET_W'(1);                        // [R18] [R21]
      end
      if (!selected) begin
         state_next = ST_IDLE;
         timed_next = trig_level;                                      // [R9] [R3]
         track_next = trig_level;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               timed_next = 1'b0;
               track_next = 1'b0;
               if (trig_rise) begin
                  state_next = ST_ON_WAIT;                             // [R1] [R4]
                  load_on    = 1'b1;
                  count_next = on_preset;                              // [R1] [R19]
                  track_next = ~on_delay_mode;                         // [R12] [R7]
               end
            end
            ST_ON_WAIT: begin
               if (trig_fall) begin
                  state_next = ST_IDLE;                                // [R2] [R13]
                  timed_next = 1'b0;
                  track_next = 1'b0;
               end else if (expired) begin
                  state_next = ST_HIGH;
                  timed_next = 1'b1;                                   // [R2] [R13] [R16]
                  track_next = on_delay_mode;                          // [R7] [R13]
               end
            end
            ST_HIGH: begin
               if (trig_fall && on_delay_mode) begin
                  state_next = ST_IDLE;                                // [R6]
                  timed_next = 1'b0;
                  track_next = 1'b0;
               end else if (trig_fall) begin
                  state_next = ST_OFF_WAIT;                            // [R14]
                  load_off   = 1'b1;
                  count_next = off_preset;                             // [R15]
                  track_next = 1'b1;                                   // [R14] [R17]
               end
            end
            ST_OFF_WAIT: begin
               if (trig_rise) begin
                  state_next = ST_HIGH;                                // [R20]
                  track_next = 1'b0;
               end else if (expired) begin
                  state_next = ST_IDLE;                                // [R20]
                  timed_next = 1'b0;
                  track_next = 1'b0;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg <= ST_IDLE;
         count_reg <= PRESET_RST;
         timed_reg <= 1'b0;
         track_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         timed_reg <= timed_next;
         track_reg <= track_next;
      end
   end

   assign o_timed_output    = timed_reg;
   assign o_tracking_output = track_reg;                               // [R17]

   // ************************************************************
   // register port
   // ************************************************************
   assign status_word = '{zero: 12'h000, busy: (state_reg != ST_IDLE),
                          trigger: trig_level, tracking: track_reg, timed: timed_reg};

   assign rd_mux = (i_addr == CTRL_OFS)   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg} :
                   (i_addr == FIRST_OFS)  ? first_reg :
                   (i_addr == SECOND_OFS) ? second_reg :
                   (i_addr == STATUS_OFS) ? status_word : RDATA_RST;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_reg   <= CTRL_RST;
         first_reg  <= PRESET_RST;
         second_reg <= PRESET_RST;
         rdata_reg  <= RDATA_RST;
      end else begin
         if (i_wr && i_addr == CTRL_OFS) begin
            ctrl_reg <= ctrl_t'(i_wdata[CTRL_W-1:0]);
         end
         if (i_wr && i_addr == FIRST_OFS) begin
            first_reg <= i_wdata;
         end
         if (i_wr && i_addr == SECOND_OFS) begin
            second_reg <= i_wdata;
         end
         rdata_reg <= i_rd ? rd_mux : RDATA_RST;
      end
   end

   assign o_rdata = rdata_reg;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_launch_on;
      selected && state_reg == ST_IDLE && trig_rise;
   endsequence

   sequence s_expire_on;
      selected && state_reg == ST_ON_WAIT && !trig_fall && expired;
   endsequence

   sequence s_launch_off;
      selected && !on_delay_mode && state_reg == ST_HIGH && trig_fall;
   endsequence

   a_launch_on_preset: assert property (s_launch_on |=> // [R1] [R19] [R11]
      state_reg == ST_ON_WAIT && count_reg == $past(on_preset))
      else $error("on-delay launch loaded wrong preset");

   a_rise_sets_track: assert property (s_launch_on ##0 !on_delay_mode |=> // [R12]
      o_tracking_output && !o_timed_output)
      else $error("on/off launch did not raise tracking");

   a_expire_sets_out: assert property (s_expire_on |=> // [R2] [R13] [R16]
      o_timed_output && (o_tracking_output == $past(on_delay_mode)))
      else $error("on expiry gave wrong outputs");

   a_short_pulse_low: assert property ( // [R2] [R13]
      selected && state_reg == ST_ON_WAIT && trig_fall |=> !o_timed_output && state_reg == ST_IDLE)
      else $error("short pulse produced output");

   a_fall_clears_out: assert property ( // [R6]
      selected && on_delay_mode && state_reg == ST_HIGH && trig_fall |=> !o_timed_output)
      else $error("on-delay output held after fall");

   a_outputs_mirror: assert property ( // [R7]
      $past(on_delay_mode) && $past(selected) |-> o_timed_output == o_tracking_output)
      else $error("timed and tracking differ in on-delay mode");

   a_bypass_follows: assert property (!selected |=> o_timed_output == $past(trig_level)) // [R9]
      else $error("bypassed stage did not follow trigger");

   a_off_launch_pair: assert property (s_launch_off |=> // [R14] [R15]
      o_tracking_output && o_timed_output && count_reg == $past(off_preset))
      else $error("off-delay launch wrong");

   a_off_expire_clear: assert property ( // [R20]
      selected && state_reg == ST_OFF_WAIT && !trig_rise && expired |=>
      !o_timed_output && !o_tracking_output)
      else $error("off expiry did not clear outputs");

   a_off_retrigger: assert property ( // [R20]
      selected && state_reg == ST_OFF_WAIT && trig_rise |=> o_timed_output ##1 o_timed_output || trig_fall)
      else $error("retrigger during off-delay lost output");

   a_count_step: assert property ( // [R18] [R21]
      selected && tick && !expired && !restart && state_reg != ST_IDLE |=>
      count_reg == $past(count_reg) - PRESET_W'(1))
      else $error("time-out counter did not step on tick");

   a_count_hold: assert property ( // [R21]
      !tick && !restart && selected |=> count_reg == $past(count_reg))
      else $error("time-out counter moved without tick");

   sequence s_off_hold;
      selected && state_reg == ST_OFF_WAIT && !trig_rise && !expired;
   endsequence

   a_off_wait_hold: assert property (s_off_hold |=> // [R14] [R20]
      o_timed_output && o_tracking_output)
      else $error("off-delay wait lost outputs");

   a_on_wait_low: assert property ( // [R2] [R13]
      selected && state_reg == ST_ON_WAIT && !trig_fall && !expired |=> !o_timed_output)
      else $error("output rose before time-out expired");

   a_bypass_track: assert property (!selected |=> o_tracking_output == $past(trig_level)) // [R9]
      else $error("bypassed stage tracking did not follow trigger");

endmodule

// *** verification/trigger_source.sv ***
// Purpose : upstream discrete source that drives the first block's trigger
// Assumes : the bench asks for a level; the source registers it on the clock
// Notes   : i_slow adds two cycles of lag, like a slower upstream stage

`timescale 1ns/100ps

module trigger_source (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_level,
   input  wire logic i_slow,
   output logic      o_pin
);
   // ************************************************************
   // lag line, held low in reset like a de-energised input
   // ************************************************************
   logic [2:0] lag_reg;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         lag_reg <= 3'h0;
      end else begin
         lag_reg <= {lag_reg[1:0], i_level};
      end
   end

   assign o_pin = i_slow ? lag_reg[2] : lag_reg[0];
endmodule

// *** verification/tb.sv ***
// Purpose : self-checking bench for the selectable delay timer, single and chained
// Assumes : presets are kept small so that each time-out lasts a few ticks
// Notes   : expectations come from the bench functions, never from the design

`timescale 1ns/100ps

`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
   import delay_timer_pkg::*;

   // ************************************************************
   // signals
   // ************************************************************
   logic              i_clk;
   logic              i_sys_rst;
   logic              level;
   logic              slow;
   logic              wr0;
   logic              wr1;
   logic              rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic              trig;
   logic              timed;
   logic              track;
   logic              c_timed;
   logic              c_track;
   int                failures = 0;
   int                check_count = 0;
   int                p1;
   int                p2;

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   trigger_source src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_level(level),
      .i_slow(slow), .o_pin(trig));

   selectable_delay_timer DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_trigger(trig),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr0), .i_rd(rd), .o_rdata(rdata),
      .o_timed_output(timed), .o_tracking_output(track));

   // second stage of a chain, fed by the first block's timed output
   selectable_delay_timer chain_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_trigger(timed), .i_addr(addr), .i_wdata(wdata), .i_wr(wr1), .i_rd(1'b0),
      .o_rdata(), .o_timed_output(c_timed), .o_tracking_output(c_track));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic int pick_ticks(input logic ch, input logic off, input int a, input int b);
      return (ch ^ off) ? b : a;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic wr(input logic sel, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr0 <= ~sel;
      wr1 <= sel;
      @(posedge i_clk);
      wr0 <= 1'b0;
      wr1 <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      @(negedge i_clk);
      `CHECK(rdata, exp)
   endtask

   task automatic trig_to(input logic v);
      @(posedge i_clk);
      level <= v;
   endtask

   task automatic look(input int n, input logic t, input logic k);
      cyc(n);
      @(negedge i_clk);
      `CHECK(timed, t)
      `CHECK(track, k)
   endtask

   // control written only while the trigger is low
   task automatic set_up(input logic sel, input logic mode, input logic ch, input logic pick);
      wr(sel, FIRST_OFS, p1[15:0]);
      wr(sel, SECOND_OFS, p2[15:0]);
      wr(sel, CTRL_OFS, {13'h0000, pick, ch, mode});
   endtask

   task automatic run_on(input logic ch);
      int n;
      n = pick_ticks(ch, 1'b0, p1, p2);
      set_up(1'b0, 1'b0, ch, 1'b0);
      rd_chk(SECOND_OFS, p2[15:0]);
      trig_to(1'b1);
      look(n * TICK_CYCLES - 100, 1'b0, 1'b0);
      look(200, 1'b1, 1'b1);
      rd_chk(STATUS_OFS, 16'h000F);
      trig_to(1'b0);
      look(8, 1'b0, 1'b0);
      cyc(10);
   endtask

   task automatic run_on_off(input logic ch);
      int on_n;
      int off_n;
      on_n = pick_ticks(ch, 1'b0, p1, p2);
      off_n = pick_ticks(ch, 1'b1, p1, p2);
      set_up(1'b0, 1'b1, ch, 1'b0);
      trig_to(1'b1);
      look(8, 1'b0, 1'b1);
      look(on_n * TICK_CYCLES - 108, 1'b0, 1'b1);
      look(200, 1'b1, 1'b0);
      trig_to(1'b0);
      look(8, 1'b1, 1'b1);
      look(off_n * TICK_CYCLES - 108, 1'b1, 1'b1);
      look(200, 1'b0, 1'b0);
   endtask

   task automatic end_test(input string s);
      $display("test %s done, checks=%0d", s, check_count);
   endtask

   task final_report;
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      i_sys_rst = 1'b1;
      level = 1'b0;
      slow = 1'b0;
      wr0 = 1'b0;
      wr1 = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      void'($urandom(32'h7505));
      cyc(3);
      i_sys_rst <= 1'b0;
      rd_chk(CTRL_OFS, 16'h0004);
      rd_chk(FIRST_OFS, 16'h0000);
      wr(1'b0, 8'h10, 16'hFFFF);
      wr(1'b0, STATUS_OFS, 16'hFFFF);
      rd_chk(CTRL_OFS, 16'h0004);
      rd_chk(STATUS_OFS, 16'h0000);
      rd_chk(8'h10, 16'h0000);
      end_test("registers");
      trig_to(1'b1);
      look(6, 1'b1, 1'b1);
      trig_to(1'b0);
      look(6, 1'b0, 1'b0);
      end_test("bypass");
      p1 = 1;
      p2 = 2;
      run_on(1'b0);
      run_on(1'b1);
      set_up(1'b0, 1'b0, 1'b0, 1'b0);
      trig_to(1'b1);
      look(1000, 1'b0, 1'b0);
      trig_to(1'b0);
      look(3000, 1'b0, 1'b0);
      end_test("on-delay");
      run_on_off(1'b0);
      run_on_off(1'b1);
      // retrigger inside the off-delay, then a pulse shorter than the on-delay
      set_up(1'b0, 1'b1, 1'b0, 1'b0);
      trig_to(1'b1);
      look(p1 * TICK_CYCLES + 100, 1'b1, 1'b0);
      trig_to(1'b0);
      look(1000, 1'b1, 1'b1);
      trig_to(1'b1);
      look(8, 1'b1, 1'b0);
      look(p2 * TICK_CYCLES, 1'b1, 1'b0);
      trig_to(1'b0);
      look(p2 * TICK_CYCLES + 300, 1'b0, 1'b0);
      trig_to(1'b1);
      look(1000, 1'b0, 1'b1);
      trig_to(1'b0);
      look(8, 1'b0, 1'b0);
      end_test("on-off");
      for (int i = 0; i < 4; i++) begin
         p1 = $urandom_range(3, 1);
         p2 = $urandom_range(3, 1);
         slow <= 1'($urandom_range(1, 0));
         run_on(1'($urandom_range(1, 0)));
      end
      slow <= 1'b0;
      end_test("random");
      // first stage bypassed, second selected: only one stage has pick 0
      p1 = 1;
      set_up(1'b0, 1'b0, 1'b0, 1'b1);
      set_up(1'b1, 1'b0, 1'b0, 1'b0);
      trig_to(1'b1);
      look(2400, 1'b1, 1'b1);
      `CHECK(c_timed, 1'b0)
      look(200, 1'b1, 1'b1);
      `CHECK(c_timed, 1'b1)
      `CHECK(c_track, 1'b1)
      trig_to(1'b0);
      look(10, 1'b0, 1'b0);
      `CHECK(c_timed, 1'b0)
      set_up(1'b1, 1'b1, 1'b0, 1'b0);
      trig_to(1'b1);
      look(2600, 1'b1, 1'b1);
      `CHECK(c_timed, 1'b1)
      `CHECK(c_track, 1'b0)
      trig_to(1'b0);
      look(10, 1'b0, 1'b0);
      end_test("chain");
      final_report;
   end

   initial begin
      repeat (95000) @(posedge i_clk);
      failures++;
      $display("watchdog expired");
      final_report;
   end
endmodule
